// ### shared/acr_pkg.sv
// Package with register map, field layout and reset values of the converter configuration bank
package acr_pkg;
    // Serial word layout
    localparam int WORD_BITS = 24;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 16;
    // Register addresses
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
    localparam logic [7:0] ADDR_SLEEP_POWERDOWN_CTRL = 8'h0F;
    localparam logic [7:0] ADDR_DRIVE = 8'h11;
    localparam logic [7:0] ADDR_TERM = 8'h12;
    localparam logic [7:0] ADDR_SWAP = 8'h24;
    localparam logic [7:0] ADDR_PATTERN = 8'h25;
    localparam logic [7:0] ADDR_CODE_A = 8'h26;
    localparam logic [7:0] ADDR_CODE_B = 8'h27;
    // Field positions
    localparam int SOFT_RESET_BIT = 0;
    localparam int SLEEP_GLOBAL_BIT = 8;
    localparam int POWER_DOWN_BIT = 9;
    localparam int PD_PIN_FN_LSB = 10;
    localparam int QUAD_LSB = 0;
    localparam int DUAL_LSB = 4;
    localparam int SINGLE_BIT = 6;
    localparam int DRV_BCLK_LSB = 0;
    localparam int DRV_FCLK_LSB = 4;
    localparam int DRV_DATA_LSB = 8;
    localparam int TERM_EN_BIT = 14;
    localparam int PAT_CONST_BIT = 4;
    localparam int PAT_TOGGLE_BIT = 5;
    localparam int PAT_RAMP_BIT = 6;
    // Writable bit masks, others read as zero
    localparam logic [15:0] MASK_SLEEP_POWERDOWN_CTRL = 16'h0F7F;
    localparam logic [15:0] MASK_DRIVE = 16'h0777;
    localparam logic [15:0] MASK_TERM = 16'h4777;
    localparam logic [15:0] MASK_SWAP = 16'h007F;
    localparam logic [15:0] MASK_PATTERN = 16'h0070;
    // Reset values
    localparam logic [15:0] RST_SLEEP_POWERDOWN_CTRL = 16'h0000;
    localparam logic [15:0] RST_DRIVE = 16'h0000;
    localparam logic [15:0] RST_TERM = 16'h0000;
    localparam logic [15:0] RST_SWAP = 16'h0000;
    localparam logic [15:0] RST_PATTERN = 16'h0000;
    localparam logic [15:0] RST_CODE = 16'h0000;
    // Test pattern modes
    typedef enum logic [1:0] {
        PAT_OFF = 2'b00,
        PAT_CONST = 2'b01,
        PAT_TOGGLE = 2'b10,
        PAT_RAMP = 2'b11
    } acr_pat_t;
endpackage : acr_pkg

// ### rtl/acr_serial_rx.sv
`timescale 1ns/1ps
// Serial configuration receiver: syncs pins and assembles 24-bit write words
module acr_serial_rx (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // Serial pins
    input wire logic serial_config_clk_in,
    input wire logic serial_config_data_in,
    input wire logic serial_config_select_n_in,
    // Assembled word
    output logic word_valid_out,
    output logic [7:0] word_addr_out,
    output logic [15:0] word_data_out
);
    logic [2:0] sclk_sync_ff, nxt_sclk_sync;
    logic [1:0] sdat_sync_ff, nxt_sdat_sync;
    logic [1:0] csn_sync_ff, nxt_csn_sync;
    logic [23:0] shift_ff, nxt_shift;
    logic [4:0] count_ff, nxt_count;
    logic done_ff, nxt_done;
    logic valid_ff, nxt_valid;
    logic [23:0] word_ff, nxt_word;
    logic rise;

    // Edge taken from second and third stages only, first stage is metastability guard
    assign rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];

    // Shift in on rising edges while selected; excess bits after 24 ignored
    always_comb begin
        nxt_sclk_sync = {sclk_sync_ff[1:0], serial_config_clk_in};
        nxt_sdat_sync = {sdat_sync_ff[0], serial_config_data_in};
        nxt_csn_sync = {csn_sync_ff[0], serial_config_select_n_in};
        nxt_shift = shift_ff;
        nxt_count = count_ff;
        nxt_done = done_ff;
        nxt_valid = 1'b0;
        nxt_word = word_ff;
        if (csn_sync_ff[1]) begin
            nxt_count = 5'h00;
            nxt_done = 1'b0;
        end else if (rise && !done_ff) begin
            nxt_shift = {shift_ff[22:0], sdat_sync_ff[1]}; // [R15]
            if (count_ff == 5'(acr_pkg::WORD_BITS - 1)) begin
                nxt_word = {shift_ff[22:0], sdat_sync_ff[1]};
                nxt_valid = 1'b1;
                nxt_done = 1'b1; // One word per select pulse
            end else begin
                nxt_count = count_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            sclk_sync_ff <= 3'h0;
            sdat_sync_ff <= 2'h0;
            csn_sync_ff <= 2'h3;
            shift_ff <= 24'h000000;
            count_ff <= 5'h00;
            done_ff <= 1'b0;
            valid_ff <= 1'b0;
            word_ff <= 24'h000000;
        end else begin
            sclk_sync_ff <= nxt_sclk_sync;
            sdat_sync_ff <= nxt_sdat_sync;
            csn_sync_ff <= nxt_csn_sync;
            shift_ff <= nxt_shift;
            count_ff <= nxt_count;
            done_ff <= nxt_done;
            valid_ff <= nxt_valid;
            word_ff <= nxt_word;
        end
    end

    assign word_valid_out = valid_ff;
    assign word_addr_out = word_ff[23:16];
    assign word_data_out = word_ff[15:0];
endmodule : acr_serial_rx

// ### rtl/acr_config_regs.sv
`timescale 1ns/1ps
// Converter configuration register bank with test pattern output
// Summary of operation
// [R01] Bit 0 at 0x00 resets, self-clears
// [R02] Soft reset restores all register defaults
// [R03] 0x0F bits 11:10 select powerdown pin function
// [R04] Host cycles power-down bit at start-up
// [R05] Sleep, doze and power-down bits default inactive
// [R06] 0x11 holds three drive current codes
// [R07] 0x12 bit 14 enables termination, default off
// [R08] Host sets enable when writing termination codes
// [R09] 0x24 bits 3:0 swap quad inputs
// [R10] 0x24 dual bits 5:4, single bit 6
// [R11] 0x25 bit 6 selects ramp pattern
// [R12] 0x25 bit 4 selects constant code
// [R13] 0x26 first code, reset zero
// [R14] 0x27 second code, toggle alternates codes
// [R15] 24-bit word: address then 16 data
module acr_config_regs #(
    parameter int RAMP_BITS = 16
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // Serial configuration pins
    input wire logic serial_config_clk_in,
    input wire logic serial_config_data_in,
    input wire logic serial_config_select_n_in,
    // Converter sample tick and raw data
    input wire logic sample_tick_in,
    input wire logic [15:0] adc_data_in,
    // Power control
    input wire logic powerdown_pin_in,
    output logic [3:0] quad_channel_doze_out,
    output logic [1:0] dual_channel_doze_out,
    output logic single_channel_doze_out,
    output logic sleep_request_out,
    output logic power_down_request_out,
    output logic [1:0] powerdown_pin_function_out,
    output logic powerdown_pin_active_out,
    // Output buffer control
    output logic [2:0] bit_clock_drive_out,
    output logic [2:0] frame_clock_drive_out,
    output logic [2:0] data_drive_out,
    output logic termination_enable_out,
    output logic [2:0] bit_clock_term_out,
    output logic [2:0] frame_clock_term_out,
    output logic [2:0] data_term_out,
    // Analog input swap
    output logic [3:0] quad_input_swap_out,
    output logic [1:0] dual_input_swap_out,
    output logic single_input_swap_out,
    // Output data path
    output logic [15:0] sample_data_out,
    output logic soft_reset_pulse_out
);
    logic word_valid;
    logic [7:0] word_addr;
    logic [15:0] word_data;
    logic [15:0] sleep_powerdown_ctrl_ff, nxt_sleep_powerdown_ctrl;
    logic [15:0] drive_ff, nxt_drive;
    logic [15:0] term_ff, nxt_term;
    logic [15:0] swap_ff, nxt_swap;
    logic [15:0] pattern_ff, nxt_pattern;
    logic [15:0] test_code_a_ff, nxt_test_code_a;
    logic [15:0] test_code_b_ff, nxt_test_code_b;
    logic soft_reset_ff, nxt_soft_reset;
    logic [1:0] pd_sync_ff, nxt_pd_sync;
    logic [RAMP_BITS-1:0] ramp_ff, nxt_ramp;
    logic toggle_ff, nxt_toggle;
    logic [15:0] sample_ff, nxt_sample;
    acr_pkg::acr_pat_t pat_mode;

    // Serial word assembly
    acr_serial_rx u_serial_rx (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .serial_config_clk_in(serial_config_clk_in),
        .serial_config_data_in(serial_config_data_in),
        .serial_config_select_n_in(serial_config_select_n_in),
        .word_valid_out(word_valid),
        .word_addr_out(word_addr),
        .word_data_out(word_data)
    );

    // Write-enable helper for one address
    function automatic logic wr_hit(input logic vld, input logic [7:0] a, input logic [7:0] target);
        wr_hit = vld && (a == target);
    endfunction : wr_hit

    // Register writes; masked bits stay zero, soft reset restores defaults
    always_comb begin
        nxt_sleep_powerdown_ctrl = sleep_powerdown_ctrl_ff;
        nxt_drive = drive_ff;
        nxt_term = term_ff;
        nxt_swap = swap_ff;
        nxt_pattern = pattern_ff;
        nxt_test_code_a = test_code_a_ff;
        nxt_test_code_b = test_code_b_ff;
        nxt_soft_reset = 1'b0; // [R01]
        if (soft_reset_ff) begin
            nxt_sleep_powerdown_ctrl = acr_pkg::RST_SLEEP_POWERDOWN_CTRL; // [R02] [R05]
            nxt_drive = acr_pkg::RST_DRIVE; // [R06]
            nxt_term = acr_pkg::RST_TERM; // [R07]
            nxt_swap = acr_pkg::RST_SWAP;
            nxt_pattern = acr_pkg::RST_PATTERN;
            nxt_test_code_a = acr_pkg::RST_CODE; // [R13]
            nxt_test_code_b = acr_pkg::RST_CODE;
        end else if (wr_hit(word_valid, word_addr, acr_pkg::ADDR_SOFT_RESET)) begin
            nxt_soft_reset = word_data[acr_pkg::SOFT_RESET_BIT]; // [R01]
        end else if (wr_hit(word_valid, word_addr, acr_pkg::ADDR_SLEEP_POWERDOWN_CTRL)) begin
            nxt_sleep_powerdown_ctrl = word_data & acr_pkg::MASK_SLEEP_POWERDOWN_CTRL; // [R03] [R05]
        end else if (wr_hit(word_valid, word_addr, acr_pkg::ADDR_DRIVE)) begin
            nxt_drive = word_data & acr_pkg::MASK_DRIVE; // [R06]
        end else if (wr_hit(word_valid, word_addr, acr_pkg::ADDR_TERM)) begin
            nxt_term = word_data & acr_pkg::MASK_TERM; // [R07]
        end else if (wr_hit(word_valid, word_addr, acr_pkg::ADDR_SWAP)) begin
            nxt_swap = word_data & acr_pkg::MASK_SWAP; // [R09] [R10]
        end else if (wr_hit(word_valid, word_addr, acr_pkg::ADDR_PATTERN)) begin
            nxt_pattern = word_data & acr_pkg::MASK_PATTERN; // [R11] [R12]
        end else if (wr_hit(word_valid, word_addr, acr_pkg::ADDR_CODE_A)) begin
            nxt_test_code_a = word_data; // [R13]
        end else if (wr_hit(word_valid, word_addr, acr_pkg::ADDR_CODE_B)) begin
            nxt_test_code_b = word_data; // [R14]
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            sleep_powerdown_ctrl_ff <= acr_pkg::RST_SLEEP_POWERDOWN_CTRL;
            drive_ff <= acr_pkg::RST_DRIVE;
            term_ff <= acr_pkg::RST_TERM;
            swap_ff <= acr_pkg::RST_SWAP;
            pattern_ff <= acr_pkg::RST_PATTERN;
            test_code_a_ff <= acr_pkg::RST_CODE;
            test_code_b_ff <= acr_pkg::RST_CODE;
            soft_reset_ff <= 1'b0;
        end else begin
            sleep_powerdown_ctrl_ff <= nxt_sleep_powerdown_ctrl;
            drive_ff <= nxt_drive;
            term_ff <= nxt_term;
            swap_ff <= nxt_swap;
            pattern_ff <= nxt_pattern;
            test_code_a_ff <= nxt_test_code_a;
            test_code_b_ff <= nxt_test_code_b;
            soft_reset_ff <= nxt_soft_reset;
        end
    end

    // Pattern mode decode; with conflicting selects ramp wins, then toggle
    always_comb begin
        if (pattern_ff[acr_pkg::PAT_RAMP_BIT]) begin
            pat_mode = acr_pkg::PAT_RAMP; // [R11]
        end else if (pattern_ff[acr_pkg::PAT_TOGGLE_BIT]) begin
            pat_mode = acr_pkg::PAT_TOGGLE; // [R14]
        end else if (pattern_ff[acr_pkg::PAT_CONST_BIT]) begin
            pat_mode = acr_pkg::PAT_CONST; // [R12]
        end else begin
            pat_mode = acr_pkg::PAT_OFF;
        end
    end

    // Output data path, advanced once per sample tick
    always_comb begin
        nxt_pd_sync = {pd_sync_ff[0], powerdown_pin_in};
        nxt_ramp = ramp_ff;
        nxt_toggle = toggle_ff;
        nxt_sample = sample_ff;
        if (pat_mode != acr_pkg::PAT_RAMP) begin
            nxt_ramp = '0;
        end
        if (pat_mode != acr_pkg::PAT_TOGGLE) begin
            nxt_toggle = 1'b0;
        end
        if (sample_tick_in) begin
            case (pat_mode)
                acr_pkg::PAT_RAMP: begin
                    nxt_sample = 16'(ramp_ff); // [R11]
                    nxt_ramp = ramp_ff + 1'b1;
                end
                acr_pkg::PAT_TOGGLE: begin
                    nxt_sample = toggle_ff ? test_code_b_ff : test_code_a_ff; // [R14]
                    nxt_toggle = ~toggle_ff;
                end
                acr_pkg::PAT_CONST: begin
                    nxt_sample = test_code_a_ff; // [R12]
                end
                default: begin
                    nxt_sample = adc_data_in;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            pd_sync_ff <= 2'h0;
            ramp_ff <= '0;
            toggle_ff <= 1'b0;
            sample_ff <= 16'h0000;
        end else begin
            pd_sync_ff <= nxt_pd_sync;
            ramp_ff <= nxt_ramp;
            toggle_ff <= nxt_toggle;
            sample_ff <= nxt_sample;
        end
    end

    // Register fields to analog and buffer controls
    assign quad_channel_doze_out = sleep_powerdown_ctrl_ff[acr_pkg::QUAD_LSB +: 4];
    assign dual_channel_doze_out = sleep_powerdown_ctrl_ff[acr_pkg::DUAL_LSB +: 2];
    assign single_channel_doze_out = sleep_powerdown_ctrl_ff[acr_pkg::SINGLE_BIT];
    assign sleep_request_out = sleep_powerdown_ctrl_ff[acr_pkg::SLEEP_GLOBAL_BIT];
    assign power_down_request_out = sleep_powerdown_ctrl_ff[acr_pkg::POWER_DOWN_BIT]; // [R04]
    assign powerdown_pin_function_out = sleep_powerdown_ctrl_ff[acr_pkg::PD_PIN_FN_LSB +: 2]; // [R03]
    assign powerdown_pin_active_out = pd_sync_ff[1];
    assign bit_clock_drive_out = drive_ff[acr_pkg::DRV_BCLK_LSB +: 3];
    assign frame_clock_drive_out = drive_ff[acr_pkg::DRV_FCLK_LSB +: 3];
    assign data_drive_out = drive_ff[acr_pkg::DRV_DATA_LSB +: 3];
    // Codes pass only while enable is set; a write omitting it leaves buffers unterminated
    assign termination_enable_out = term_ff[acr_pkg::TERM_EN_BIT]; // [R07]
    assign bit_clock_term_out = termination_enable_out ? term_ff[acr_pkg::DRV_BCLK_LSB +: 3] : 3'h0; // [R08]
    assign frame_clock_term_out = termination_enable_out ? term_ff[acr_pkg::DRV_FCLK_LSB +: 3] : 3'h0;
    assign data_term_out = termination_enable_out ? term_ff[acr_pkg::DRV_DATA_LSB +: 3] : 3'h0;
    assign quad_input_swap_out = swap_ff[acr_pkg::QUAD_LSB +: 4]; // [R09]
    assign dual_input_swap_out = swap_ff[acr_pkg::DUAL_LSB +: 2]; // [R10]
    assign single_input_swap_out = swap_ff[acr_pkg::SINGLE_BIT];
    assign sample_data_out = sample_ff;
    assign soft_reset_pulse_out = soft_reset_ff;
endmodule : acr_config_regs

// ### tb/acr_host_model.sv
`timescale 1ns/1ps
// Host controller model writing words over the serial configuration pins
module acr_host_model (
    // Clock
    input wire logic mclk_in,
    // Serial pins
    output logic sclk_out,
    output logic serial_config_data_out,
    output logic csel_n_out
);
    // Idle pins; serial clock stands low outside frames
    initial begin
        sclk_out = 1'b0;
        serial_config_data_out = 1'b1;
        csel_n_out = 1'b1;
    end
    // One word per select pulse, address then data, MSB first; 4 mclk per clock phase
    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        logic [23:0] w;
        w = {a, d};
        @(posedge mclk_in) csel_n_out <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge mclk_in) serial_config_data_out <= w[i];
            repeat (3) @(posedge mclk_in);
            sclk_out <= 1'b1;
            repeat (4) @(posedge mclk_in);
            sclk_out <= 1'b0;
        end
        repeat (3) @(posedge mclk_in);
        csel_n_out <= 1'b1;
        serial_config_data_out <= ~w[0]; // Released line must not keep the last bit
        repeat (12) @(posedge mclk_in);
    endtask : write_word
endmodule : acr_host_model

// ### tb/acr_config_regs_checker.sv
`timescale 1ns/1ps
// Port-level assertions for the configuration bank
module acr_config_regs_checker (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic serial_config_select_n_in,
    input wire logic sample_tick_in,
    input wire logic powerdown_pin_in,
    input wire logic [3:0] quad_channel_doze_out,
    input wire logic [1:0] dual_channel_doze_out,
    input wire logic single_channel_doze_out,
    input wire logic sleep_request_out,
    input wire logic power_down_request_out,
    input wire logic [1:0] powerdown_pin_function_out,
    input wire logic powerdown_pin_active_out,
    input wire logic [2:0] bit_clock_drive_out,
    input wire logic [2:0] frame_clock_drive_out,
    input wire logic [2:0] data_drive_out,
    input wire logic termination_enable_out,
    input wire logic [2:0] bit_clock_term_out,
    input wire logic [2:0] frame_clock_term_out,
    input wire logic [2:0] data_term_out,
    input wire logic [3:0] quad_input_swap_out,
    input wire logic [1:0] dual_input_swap_out,
    input wire logic single_input_swap_out,
    input wire logic [15:0] sample_data_out,
    input wire logic soft_reset_pulse_out
);
    logic [7:0] idle_ff;
    logic [7:0] nxt_idle;
    logic [36:0] cfg;
    assign cfg = {quad_channel_doze_out, dual_channel_doze_out, single_channel_doze_out, sleep_request_out,
        power_down_request_out, powerdown_pin_function_out, bit_clock_drive_out, frame_clock_drive_out,
        data_drive_out, termination_enable_out, bit_clock_term_out, frame_clock_term_out, data_term_out,
        quad_input_swap_out, dual_input_swap_out, single_input_swap_out};
    // Cycles since select was last low; saturates so a long idle never wraps
    always_comb begin
        nxt_idle = idle_ff;
        if (!serial_config_select_n_in) nxt_idle = 8'h00;
        else if (idle_ff != 8'hFF) nxt_idle = idle_ff + 8'h01;
    end
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) idle_ff <= 8'h00;
        else idle_ff <= nxt_idle;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    chk_pulse_one_cycle: assert property (soft_reset_pulse_out |=> !soft_reset_pulse_out)
        else $error("soft reset pulse longer than one cycle");
    chk_pulse_from_write: assert property ($rose(soft_reset_pulse_out) |-> idle_ff < 8'h10)
        else $error("soft reset pulse without a write");
    chk_soft_defaults: assert property (soft_reset_pulse_out |=> cfg == 37'h0)
        else $error("settings not cleared after soft reset");
    chk_hw_defaults: assert property ($rose(rstn_in) |-> cfg == 37'h0 && sample_data_out == 16'h0000)
        else $error("outputs not inactive after reset");
    chk_term_gated: assert property (!termination_enable_out |->
        {bit_clock_term_out, frame_clock_term_out, data_term_out} == 9'h000)
        else $error("termination codes active while disabled");
    chk_cfg_quiet: assert property (idle_ff >= 8'h10 |=> $stable(cfg))
        else $error("settings changed without a serial word");
    chk_pin_sync: assert property ($past(rstn_in) && $past(rstn_in, 2) |->
        powerdown_pin_active_out == $past(powerdown_pin_in, 2))
        else $error("powerdown pin not followed after two cycles");
    chk_sample_hold: assert property ($past(rstn_in) && !$past(sample_tick_in) &&
        !$past(soft_reset_pulse_out) |-> $stable(sample_data_out))
        else $error("sample output changed without a tick");
endmodule : acr_config_regs_checker
bind acr_config_regs acr_config_regs_checker i_chk (.mclk_in, .rstn_in, .serial_config_select_n_in, .sample_tick_in,
    .powerdown_pin_in, .quad_channel_doze_out, .dual_channel_doze_out, .single_channel_doze_out, .sleep_request_out,
    .power_down_request_out, .powerdown_pin_function_out, .powerdown_pin_active_out, .bit_clock_drive_out,
    .frame_clock_drive_out, .data_drive_out, .termination_enable_out, .bit_clock_term_out, .frame_clock_term_out,
    .data_term_out, .quad_input_swap_out, .dual_input_swap_out, .single_input_swap_out, .sample_data_out,
    .soft_reset_pulse_out);

// ### tb/acr_config_regs_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the converter configuration bank
module acr_config_regs_tb;
    logic mclk_in, rstn_in, sample_tick_in, powerdown_pin_in, sclk, serial_config_data, csel_n;
    logic [15:0] adc_data_in, sample_data_out, v0, v1, v2;
    logic [3:0] quad_channel_doze_out, quad_input_swap_out;
    logic [1:0] dual_channel_doze_out, powerdown_pin_function_out, dual_input_swap_out;
    logic single_channel_doze_out, sleep_request_out, power_down_request_out, powerdown_pin_active_out;
    logic termination_enable_out, single_input_swap_out, soft_reset_pulse_out;
    logic [2:0] bit_clock_drive_out, frame_clock_drive_out, data_drive_out;
    logic [2:0] bit_clock_term_out, frame_clock_term_out, data_term_out;
    int mismatches = 0;
    int n_compared = 0;
    wire logic any_set = |{quad_channel_doze_out, dual_channel_doze_out, single_channel_doze_out, sleep_request_out,
        power_down_request_out, powerdown_pin_function_out, bit_clock_drive_out, frame_clock_drive_out, data_drive_out,
        termination_enable_out, quad_input_swap_out, dual_input_swap_out, single_input_swap_out};
    acr_config_regs i_dut (.mclk_in, .rstn_in, .serial_config_clk_in(sclk), .serial_config_data_in(serial_config_data),
        .serial_config_select_n_in(csel_n), .sample_tick_in, .adc_data_in, .powerdown_pin_in,
        .quad_channel_doze_out, .dual_channel_doze_out, .single_channel_doze_out, .sleep_request_out,
        .power_down_request_out, .powerdown_pin_function_out, .powerdown_pin_active_out, .bit_clock_drive_out,
        .frame_clock_drive_out, .data_drive_out, .termination_enable_out, .bit_clock_term_out,
        .frame_clock_term_out, .data_term_out, .quad_input_swap_out, .dual_input_swap_out,
        .single_input_swap_out, .sample_data_out, .soft_reset_pulse_out);
    acr_host_model i_host (.mclk_in, .sclk_out(sclk), .serial_config_data_out(serial_config_data), .csel_n_out(csel_n));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask : check
    task automatic stop_test;
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    // One-cycle tick, sample read once the registered output has landed
    task automatic tick(output logic [15:0] v);
        @(posedge mclk_in) sample_tick_in <= 1'b1;
        @(posedge mclk_in) sample_tick_in <= 1'b0;
        #1 v = sample_data_out;
    endtask : tick
    // Power-down cycling, every pin function code, masked sleep bits, pin sync
    task automatic t_power;
        i_host.write_word(acr_pkg::ADDR_SLEEP_POWERDOWN_CTRL, 16'h0200);
        check({15'h0, power_down_request_out}, 16'h0001);
        i_host.write_word(acr_pkg::ADDR_SLEEP_POWERDOWN_CTRL, 16'h0000);
        check({15'h0, power_down_request_out}, 16'h0000);
        for (int f = 0; f < 4; f++) begin
            i_host.write_word(acr_pkg::ADDR_SLEEP_POWERDOWN_CTRL, {4'h0, f[1:0], 10'h000});
            check({14'h0, powerdown_pin_function_out}, {14'h0, f[1:0]});
        end
        i_host.write_word(acr_pkg::ADDR_SLEEP_POWERDOWN_CTRL, 16'hFFFF);
        check({4'h0, powerdown_pin_function_out, power_down_request_out, sleep_request_out, 1'b0,
            single_channel_doze_out, dual_channel_doze_out, quad_channel_doze_out}, acr_pkg::MASK_SLEEP_POWERDOWN_CTRL);
        @(posedge mclk_in) powerdown_pin_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        #1 check({15'h0, powerdown_pin_active_out}, 16'h0001);
        @(posedge mclk_in) powerdown_pin_in <= 1'b0;
    endtask : t_power
    // Drive codes, termination with and without its enable
    task automatic t_buffers;
        i_host.write_word(acr_pkg::ADDR_DRIVE, 16'hF765);
        check({5'h0, data_drive_out, 1'b0, frame_clock_drive_out, 1'b0, bit_clock_drive_out}, 16'h0765);
        i_host.write_word(acr_pkg::ADDR_TERM, 16'h0123);
        check({1'b0, termination_enable_out, 3'h0, data_term_out, 1'b0, frame_clock_term_out, 1'b0,
            bit_clock_term_out}, 16'h0000);
        i_host.write_word(acr_pkg::ADDR_TERM, 16'hC123);
        check({1'b0, termination_enable_out, 3'h0, data_term_out, 1'b0, frame_clock_term_out, 1'b0,
            bit_clock_term_out}, 16'h4123);
    endtask : t_buffers
    // Input swap fields, then an unmapped address that must change nothing
    task automatic t_swap;
        i_host.write_word(acr_pkg::ADDR_SWAP, 16'hFF5A);
        check({9'h0, single_input_swap_out, dual_input_swap_out, quad_input_swap_out}, 16'h005A);
        i_host.write_word(acr_pkg::ADDR_SWAP, 16'h0025);
        i_host.write_word(8'h50, 16'hFFFF);
        check({9'h0, single_input_swap_out, dual_input_swap_out, quad_input_swap_out}, 16'h0025);
    endtask : t_swap
    // Pass-through, constant, toggle and ramp patterns
    task automatic t_pattern;
        tick(v0);
        check(v0, 16'hC3A5);
        i_host.write_word(acr_pkg::ADDR_CODE_A, 16'h1234);
        i_host.write_word(acr_pkg::ADDR_CODE_B, 16'hABCD);
        i_host.write_word(acr_pkg::ADDR_PATTERN, 16'h0010);
        tick(v0);
        check(v0, 16'h1234);
        i_host.write_word(acr_pkg::ADDR_PATTERN, 16'h0020);
        tick(v0);
        tick(v1);
        tick(v2);
        check(v0, 16'h1234);
        check(v1, 16'hABCD);
        check(v0 ^ v1, 16'hB9F9);
        check(v2, 16'h1234);
        i_host.write_word(acr_pkg::ADDR_PATTERN, 16'h0040);
        tick(v0);
        tick(v1);
        check(v0, 16'h0000);
        check(v1, 16'h0001);
    endtask : t_pattern
    // Soft reset: bit 0 clear does nothing, bit 0 set pulses once and restores defaults
    task automatic t_soft_reset;
        int n;
        i_host.write_word(acr_pkg::ADDR_SOFT_RESET, 16'h0000);
        check({15'h0, any_set}, 16'h0001);
        fork
            i_host.write_word(acr_pkg::ADDR_SOFT_RESET, 16'h0001);
            begin
                n = 0;
                while (n < 400 && soft_reset_pulse_out !== 1'b1) begin
                    @(posedge mclk_in);
                    #1 n++;
                end
                if (n == 400) begin
                    mismatches++;
                    stop_test;
                end else begin
                    @(posedge mclk_in);
                    #1 check({14'h0, soft_reset_pulse_out, any_set}, 16'h0000);
                end
            end
        join
        i_host.write_word(acr_pkg::ADDR_PATTERN, 16'h0010);
        tick(v0);
        check(v0, 16'h0000);
    endtask : t_soft_reset
    // Clock
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge mclk_in);
        mismatches++;
        stop_test;
    end
    // Main sequence
    initial begin
        rstn_in = 1'b0;
        sample_tick_in = 1'b0;
        powerdown_pin_in = 1'b0;
        adc_data_in = 16'hC3A5;
        repeat (20) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        #1 check({15'h0, any_set}, 16'h0000);
        t_power();
        t_buffers();
        t_swap();
        t_pattern();
        t_soft_reset();
        stop_test();
    end
endmodule : acr_config_regs_tb
